/* File: inc/msl_pkg.sv */
package msl_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_HOLD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [3:0] LIMIT_RST = 4'h1;
  localparam logic [3:0] LIMIT_MIN = 4'h1;
  localparam logic [3:0] LIMIT_MAX = 4'hA;
  localparam logic [6:0] HOLD_RST = 7'h01;
  localparam logic [6:0] HOLD_MIN = 7'h01;
  localparam logic [6:0] HOLD_MAX = 7'h78;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // current levels, percent of rated
  // ----------------------------------------
  localparam logic [1:0] CUR_LOW = 2'h0;
  localparam logic [1:0] CUR_MID = 2'h1;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int RISE_MS = 60;
  localparam int SETTLE_MS = 100;
  localparam int DELAY_MS = 1000;
  localparam int MIN_MS = 60000;
  localparam int HOUR_MS = 3600000;
  localparam int TICK_MS = TICK_US / 1000;
  localparam int RISE_TICKS = RISE_MS / TICK_MS;
  localparam int SETTLE_TICKS = (SETTLE_MS + TICK_MS - 1) / TICK_MS;
  localparam int DELAY_TICKS = DELAY_MS / TICK_MS;
  localparam int MIN_TICKS = MIN_MS / TICK_MS;
  localparam int HOUR_TICKS = HOUR_MS / TICK_MS;
  localparam int CNT_W = 26;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic below_10;
    logic above_125;
    logic above_150;
  } msl_cur_t;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } msl_rd_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HIGH = 4'b1000
  } msl_state_t;
endpackage : msl_pkg

/* File: hw/msl_timer.sv */
module msl_timer #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic clr_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [W-1:0] limit_in,
  output logic done_out
);
  // ----------------------------------------
  // tick counter, saturates at limit
  // ----------------------------------------
  logic [W-1:0] count;
  wire reached = (count >= limit_in);
  assign done_out = run_in && reached;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else if (clr_in || !run_in) begin
      count <= '0;
    end else if (tick_in && !reached) begin
      count <= count + W'(1);
    end
  end
endmodule : msl_timer

/* File: hw/msl_limiter.sv */
// Function
// - start judging uses phase A current comparisons only.
// - start is below 10% rising above 150% within about 60 ms.
// - start completes after current stays below 125% for 100 ms.
// - each start adds one hour to the counter, even while operating.
// - counter decays with real time; one start decays in one hour.
// - counter stops at zero, never negative; new starts count from zero.
// - detect asserts when counted starts reach the start-count limit.
// - operate asserts one second after detect asserts.
// - operate holds for the hold time, 1 to 120 minutes, then drops; a new start restarts the hold time.
// - start-count limit is an integer from 1 to 10.
// - operate only while enable is on; never when off.
// - test command clears the start count to zero.
// - displayed count is internal counter rounded to nearest whole.
module msl_limiter (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic a_below_10_in,
  input wire logic a_above_125_in,
  input wire logic a_above_150_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic start_limit_detect_out,
  output logic start_limit_operate_out,
  output logic [3:0] start_count_display_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  msl_pkg::msl_cur_t cur_meta;
  msl_pkg::msl_cur_t cur;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_meta <= '0;
      cur <= '0;
    end else begin
      cur_meta <= {a_below_10_in, a_above_125_in, a_above_150_in};
      cur <= cur_meta;
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic enable;
  logic clr_req;
  logic [3:0] limit;
  logic [6:0] hold_min;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid && !aw_held && !s_axi_bvalid;
  wire w_take = s_axi_wvalid && !w_held && !s_axi_bvalid;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_ctrl = do_write && wr_addr == msl_pkg::ADDR_CTRL && wr_strb[0];
  wire wr_limit = do_write && wr_addr == msl_pkg::ADDR_LIMIT && wr_strb[0];
  wire wr_hold = do_write && wr_addr == msl_pkg::ADDR_HOLD && wr_strb[0];
  wire wr_known = wr_addr == msl_pkg::ADDR_CTRL || wr_addr == msl_pkg::ADDR_LIMIT ||
                  wr_addr == msl_pkg::ADDR_HOLD;
  wire [3:0] wr_lim_val = wr_data[3:0] < msl_pkg::LIMIT_MIN ? msl_pkg::LIMIT_MIN :
                          wr_data[3:0] > msl_pkg::LIMIT_MAX ? msl_pkg::LIMIT_MAX :
                          wr_data[3:0];
  wire [6:0] wr_hold_val = wr_data[6:0] < msl_pkg::HOLD_MIN ? msl_pkg::HOLD_MIN :
                           wr_data[6:0] > msl_pkg::HOLD_MAX ? msl_pkg::HOLD_MAX :
                           wr_data[6:0];
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= msl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? msl_pkg::RESP_OKAY : msl_pkg::RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enable <= 1'b0;
      clr_req <= 1'b0;
      limit <= msl_pkg::LIMIT_RST;
      hold_min <= msl_pkg::HOLD_RST;
    end else begin
      clr_req <= wr_ctrl && wr_data[msl_pkg::CTRL_CLR_BIT];
      if (wr_ctrl) begin
        enable <= wr_data[msl_pkg::CTRL_EN_BIT];
      end
      if (wr_limit) begin
        limit <= wr_lim_val;
      end
      if (wr_hold) begin
        hold_min <= wr_hold_val;
      end
    end
  end
  // ----------------------------------------
  // real-time tick
  // ----------------------------------------
  logic [17:0] pre;
  logic tick;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (pre == 18'(msl_pkg::TICK_CYC - 1));
      pre <= (pre == 18'(msl_pkg::TICK_CYC - 1)) ? 18'h00000 : pre + 18'h00001;
    end
  end
  // ----------------------------------------
  // start recognition
  // ----------------------------------------
  msl_pkg::msl_state_t state;
  msl_pkg::msl_state_t next_state;
  logic [6:0] rise_cnt;
  logic [6:0] settle_cnt;
  logic start_evt;
  wire rise_expired = rise_cnt >= 7'(msl_pkg::RISE_TICKS);
  wire settled = settle_cnt >= 7'(msl_pkg::SETTLE_TICKS);
  always_comb begin
    next_state = state;
    unique case (state)
      msl_pkg::ST_IDLE: begin
        if (cur.below_10) next_state = msl_pkg::ST_ARMED;
      end
      msl_pkg::ST_ARMED: begin
        if (cur.above_150) next_state = msl_pkg::ST_RUN;
        else if (!cur.below_10 && rise_expired) next_state = msl_pkg::ST_IDLE;
      end
      msl_pkg::ST_RUN: begin
        if (settled) next_state = msl_pkg::ST_IDLE;
      end
      msl_pkg::ST_HIGH: next_state = msl_pkg::ST_IDLE;
      default: next_state = msl_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= msl_pkg::ST_IDLE;
      rise_cnt <= '0;
      settle_cnt <= '0;
      start_evt <= 1'b0;
    end else begin
      state <= next_state;
      start_evt <= state == msl_pkg::ST_ARMED && next_state == msl_pkg::ST_RUN;
      if (state != msl_pkg::ST_ARMED || cur.below_10) begin
        rise_cnt <= '0;
      end else if (tick && !rise_expired) begin
        rise_cnt <= rise_cnt + 7'h01;
      end
      if (state != msl_pkg::ST_RUN || cur.above_125) begin
        settle_cnt <= '0;
      end else if (tick && !settled) begin
        settle_cnt <= settle_cnt + 7'h01;
      end
    end
  end
  // ----------------------------------------
  // decaying start counter
  // ----------------------------------------
  logic [msl_pkg::CNT_W-1:0] count;
  wire [msl_pkg::CNT_W-1:0] hour = msl_pkg::CNT_W'(msl_pkg::HOUR_TICKS);
  wire [msl_pkg::CNT_W-1:0] decayed = (tick && count != '0) ? count - 1'b1 : count;
  wire [msl_pkg::CNT_W:0] added = {1'b0, decayed} + {1'b0, hour};
  wire [msl_pkg::CNT_W-1:0] capped = added[msl_pkg::CNT_W] ? '1 : added[msl_pkg::CNT_W-1:0];
  wire [msl_pkg::CNT_W-1:0] next_count = start_evt ? capped : decayed;
  wire [msl_pkg::CNT_W+3:0] lim_ticks = limit * (msl_pkg::CNT_W+4)'(msl_pkg::HOUR_TICKS);
  wire [msl_pkg::CNT_W-1:0] half = hour >> 1;
  wire [msl_pkg::CNT_W:0] rounded = {1'b0, count} + {1'b0, half};
  wire [msl_pkg::CNT_W:0] whole = rounded / {1'b0, hour};
  wire [3:0] shown = (whole > 27'hF) ? 4'hF : whole[3:0];
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else if (clr_req) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  // ----------------------------------------
  // detect, delay and hold
  // ----------------------------------------
  logic detect;
  logic operate;
  logic fired;
  logic delay_done;
  logic hold_done;
  logic [22:0] hold_ticks;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      detect <= 1'b0;
      operate <= 1'b0;
      fired <= 1'b0;
      hold_ticks <= '0;
      start_count_display_out <= '0;
    end else begin
      hold_ticks <= 23'(hold_min * msl_pkg::MIN_TICKS);
      start_count_display_out <= shown;
      detect <= (msl_pkg::CNT_W+4)'(count) > lim_ticks - hour;
      if (!detect) begin
        fired <= 1'b0;
      end else if (operate) begin
        fired <= 1'b1;
      end
      if (!enable) begin
        operate <= 1'b0;
      end else if (delay_done && !operate) begin
        operate <= 1'b1;
      end else if (hold_done) begin
        operate <= 1'b0;
      end
    end
  end
  msl_timer #(.W(10)) u_delay (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .clr_in(operate || !enable || fired),
    .run_in(detect),
    .tick_in(tick),
    .limit_in(10'(msl_pkg::DELAY_TICKS)),
    .done_out(delay_done)
  );
  msl_timer #(.W(23)) u_hold (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .clr_in(start_evt),
    .run_in(operate),
    .tick_in(tick),
    .limit_in(hold_ticks),
    .done_out(hold_done)
  );
  assign start_limit_detect_out = detect;
  assign start_limit_operate_out = operate;
  // ----------------------------------------
  // register read
  // ----------------------------------------
  msl_pkg::msl_rd_t rd;
  wire [31:0] status_word = {29'h0, enable, operate, detect};
  assign rd.data = s_axi_araddr == msl_pkg::ADDR_CTRL ? {31'h0, enable} :
                   s_axi_araddr == msl_pkg::ADDR_LIMIT ? {28'h0, limit} :
                   s_axi_araddr == msl_pkg::ADDR_HOLD ? {25'h0, hold_min} :
                   s_axi_araddr == msl_pkg::ADDR_STATUS ? status_word :
                   s_axi_araddr == msl_pkg::ADDR_COUNT ? {6'h0, count} : 32'h0;
  assign rd.resp = (s_axi_araddr <= msl_pkg::ADDR_COUNT && s_axi_araddr[1:0] == 2'h0) ?
                   msl_pkg::RESP_OKAY : msl_pkg::RESP_SLVERR;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= msl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd.data;
      s_axi_rresp <= rd.resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : msl_limiter

/* File: dv/msl_limiter_assertions.sv */
module msl_limiter_assertions (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic a_above_150_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic start_limit_detect_out,
  input wire logic start_limit_operate_out,
  input wire logic [3:0] start_count_display_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helpers and checks
  // ----------------------------------------
  localparam int DLY_CYC = (msl_pkg::DELAY_TICKS - 1) * msl_pkg::TICK_CYC;
  logic [3:0] hi_age;
  logic [31:0] det_run;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hi_age <= 4'hF;
      det_run <= 32'h0;
    end else begin
      hi_age <= a_above_150_in ? 4'h0 : ((hi_age == 4'hF) ? hi_age : hi_age + 4'h1);
      det_run <= start_limit_detect_out ? det_run + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence clr_write_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
      && s_axi_awaddr == msl_pkg::ADDR_CTRL && s_axi_wdata[msl_pkg::CTRL_CLR_BIT];
  endsequence
  sequence count_up_s;
    start_count_display_out > $past(start_count_display_out);
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) !rstn_in |->
    !start_limit_detect_out && !start_limit_operate_out && start_count_display_out == 4'h0)
    else $error("outputs not cleared in reset");
  count_step_a: assert property (count_up_s |->
    start_count_display_out == $past(start_count_display_out) + 4'h1)
    else $error("count rose by more than one");
  start_cause_a: assert property (count_up_s |-> hi_age <= 4'h8)
    else $error("count rose without high current");
  clear_zero_a: assert property (clr_write_s |-> ##[1:4]
    start_count_display_out == 4'h0 && !start_limit_detect_out)
    else $error("test clear left a count");
  operate_delay_a: assert property ($rose(start_limit_operate_out) |-> det_run >= DLY_CYC)
    else $error("operate too soon after detect");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule : msl_limiter_assertions

bind msl_limiter msl_limiter_assertions u_chk (.clk_in, .rstn_in, .a_above_150_in,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .start_limit_detect_out, .start_limit_operate_out, .start_count_display_out);

/* File: dv/msl_front_model.sv */
module msl_front_model (
  input wire logic clk_in,
  output logic below_10_out,
  output logic above_125_out,
  output logic above_150_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // phase a comparator levels
  // ----------------------------------------
  initial begin
    below_10_out = 1'b1;
    above_125_out = 1'b0;
    above_150_out = 1'b0;
  end
  task automatic motor_start(input int hold_cyc);
    @(posedge clk_in);
    below_10_out <= 1'b1;
    above_125_out <= 1'b0;
    above_150_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    below_10_out <= 1'b0;
    above_125_out <= 1'b1;
    above_150_out <= 1'b1; // fast rise
    repeat (hold_cyc) @(posedge clk_in);
    above_150_out <= 1'b0; // running current
    above_125_out <= 1'b0;
  endtask : motor_start
endmodule : msl_front_model

/* File: dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rstn_in, a_below_10_in, a_above_125_in, a_above_150_in;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb, start_count_display_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic start_limit_detect_out, start_limit_operate_out;
  logic [31:0] cl_w [4] = '{32'h0, 32'hF, 32'h0, 32'h7F};
  logic [31:0] cl_e [4] = '{32'h1, 32'hA, 32'h1, 32'h78};
  int err_count, total_checks, cyc;
  msl_pkg::msl_rd_t rq[$];
  logic [1:0] bq[$];
  // ----------------------------------------
  // design, front end, clock
  // ----------------------------------------
  msl_limiter u_msl_limiter (.clk_in, .rstn_in, .a_below_10_in, .a_above_125_in,
    .a_above_150_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .start_limit_detect_out, .start_limit_operate_out,
    .start_count_display_out);
  msl_front_model u_front (.clk_in, .below_10_out(a_below_10_in),
    .above_125_out(a_above_125_in), .above_150_out(a_above_150_in));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = msl_pkg::RESP_OKAY);
    bit aw, w;
    aw = 0;
    w = 0;
    bq.push_back(r);
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge clk_in);
    s_axi_bready <= 1'b1;
    do @(posedge clk_in); while (s_axi_bvalid !== 1'b1 || !s_axi_bready);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = msl_pkg::RESP_OKAY);
    rq.push_back({d, r});
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_in); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic start_and_wait();
    u_front.motor_start($urandom_range(20, 5));
    for (int i = 0; i < 50 && start_count_display_out !== 4'h1; i++) @(posedge clk_in);
    check("display", start_count_display_out, 34'h1);
  endtask : start_and_wait
  // ----------------------------------------
  // result watcher and timeout
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      check("read", {s_axi_rdata, s_axi_rresp}, rq.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      check("bresp", s_axi_bresp, bq.pop_front());
    end
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    void'($urandom(82088));
    rstn_in <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(msl_pkg::ADDR_CTRL, 32'h0);
    rd(msl_pkg::ADDR_LIMIT, 32'h1);
    rd(msl_pkg::ADDR_HOLD, 32'h1);
    rd(msl_pkg::ADDR_STATUS, 32'h0);
    rd(msl_pkg::ADDR_COUNT, 32'h0);
    rd(8'h14, 32'h0, msl_pkg::RESP_SLVERR);
    wr(8'h14, 32'hFFFFFFFF, msl_pkg::RESP_SLVERR);
    rd(msl_pkg::ADDR_CTRL, 32'h0);
    foreach (cl_w[i]) begin
      wr(i < 2 ? msl_pkg::ADDR_LIMIT : msl_pkg::ADDR_HOLD, cl_w[i]);
      rd(i < 2 ? msl_pkg::ADDR_LIMIT : msl_pkg::ADDR_HOLD, cl_e[i]);
    end
    v = $urandom_range(10, 1);
    wr(msl_pkg::ADDR_LIMIT, v);
    rd(msl_pkg::ADDR_LIMIT, v);
    v = $urandom_range(120, 1);
    wr(msl_pkg::ADDR_HOLD, v);
    rd(msl_pkg::ADDR_HOLD, v);
    wr(msl_pkg::ADDR_LIMIT, 32'h2);
    wr(msl_pkg::ADDR_CTRL, 32'h1);
    start_and_wait();
    check("detect", start_limit_detect_out, 34'h0);
    rd(msl_pkg::ADDR_COUNT, 32'(msl_pkg::HOUR_TICKS));
    wr(msl_pkg::ADDR_CTRL, 32'h3);
    rd(msl_pkg::ADDR_COUNT, 32'h0);
    check("display", start_count_display_out, 34'h0);
    rd(msl_pkg::ADDR_CTRL, 32'h1);
    rstn_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    check("display", start_count_display_out, 34'h0);
    rstn_in <= 1'b1;
    rd(msl_pkg::ADDR_LIMIT, 32'h1);
    wr(msl_pkg::ADDR_CTRL, 32'h1);
    start_and_wait();
    check("detect", start_limit_detect_out, 34'h1);
    check("operate", start_limit_operate_out, 34'h0);
    rd(msl_pkg::ADDR_STATUS, 32'h5);
    wr(msl_pkg::ADDR_LIMIT, 32'hA);
    rd(msl_pkg::ADDR_STATUS, 32'h4);
    wr(msl_pkg::ADDR_LIMIT, 32'h1);
    rd(msl_pkg::ADDR_STATUS, 32'h5);
    tally_and_finish();
  end
endmodule : tb
